/* irq_cfg.svh */
// register map, field positions and reset values of the interrupt block
//
// Function
// - The third enable register holds one enable each for the interval-timer, watchdog, watch-timer and ADC requests.
// - The second enable register holds one enable each for timer 3, timer 2, timer 1, timer 0 and timer 0 overflow.
// - Each of the six groups takes a 2-bit level from one high and one low priority bit, 00 lowest and 11 highest.
// - Pending flags of external lines 0 to 7 are set by hardware and cleared only by software writing 0.
// - Pending flags of lines 10 and 13 are cleared by a software 0 or when the core acknowledges that interrupt.
// - A trigger-type bit of 0 selects level sensing and 1 selects edge sensing for its line.
// - With level sensing, polarity 0 reacts to a high level and polarity 1 to a low level.
// - With edge sensing, polarity 0 reacts to a rising edge and polarity 1 to a falling edge.
// - External lines 0 to 7, taken from port 0 bits 0 to 7, each have their own gate bit.
// - Lines 10 and 13 are gated by a two-bit register, bit 0 for line 10 and bit 1 for line 13.
// - Bit 7 of the first enable register is a master enable that blocks every request when 0.
// - The 24 sources form 6 groups of 4 and each source uses its group level.
// - A request preempts the service in progress only with a strictly higher level.
// - Among requests of equal level the lower interrupt number wins.
`ifndef IRQ_CFG_SVH
`define IRQ_CFG_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFS_GATE_10_13 8'hA3
`define OFS_PEND_10_13 8'hA4
`define OFS_TRIG_10_13 8'hA5
`define OFS_SENSE_10_13 8'hA6
`define OFS_FIRST_EN 8'hA8
`define OFS_TIMER_EN 8'hAA
`define OFS_MISC_EN 8'hAB
`define OFS_GATE_0TO7 8'hAC
`define OFS_PEND_0TO7 8'hAD
`define OFS_TRIG_0TO7 8'hAE
`define OFS_SENSE_0TO7 8'hAF
`define OFS_EVT_STAT 8'hB1
`define OFS_EVT_MASK 8'hB2
`define OFS_PRIO_LOW 8'hB8
`define OFS_PRIO_HIGH 8'hF8

// ----------------------------------------
// fields and values
// ----------------------------------------
`define REG_RESET 8'h00
`define BIT_GLOBAL_EN 7
`define BIT_EXT_0TO7_EN 5
`define BIT_EXT13_EN 2
`define BIT_EXT10_EN 1
`define SRC_EXT10 5'h01
`define SRC_EXT13 5'h02
`define SRC_EXT_0TO7 5'h05
`define SRC_TIMER0_OVF 12
`define SRC_ADC 5'h12
`define NUM_GROUPS 6
`define EVT_BITS 4

`endif

/* irq_pkg.sv */
// shared types of the interrupt block
package irq_pkg;

    typedef logic [1:0] level_t;
    typedef logic [4:0] src_t;
    typedef logic [7:0] byte_t;

endpackage

/* irq_ctrl.sv */
// interrupt enables, group priority, external line sensing and arbitration
//
// Strobed register access was decided locally.
`timescale 1ns/1ps
`include "irq_cfg.svh"

module irq_ctrl #(
    parameter int NUM_SRC = 24
) (
    // clock and reset
    input wire logic MCLK,
    input wire logic SYS_RST,
    // register port
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    // request sources
    input wire logic [7:0] EXT_P0,
    input wire logic EXT_10,
    input wire logic EXT_13,
    input wire logic [NUM_SRC-1:0] PERIPH_REQ,
    // core side
    input wire logic ACK,
    input wire logic SVC_DONE,
    output logic IRQ_REQ,
    output logic [4:0] IRQ_NUM,
    output logic [1:0] IRQ_LEVEL,
    // event summary
    output logic IRQ_OUT
);

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [7:0] first_irq_enable;
    logic [7:0] timer_irq_enable;
    logic [7:0] misc_irq_enable;
    logic [5:0] prio_low_bits;
    logic [5:0] prio_high_bits;
    logic [7:0] ext_gate_0to7;
    logic [7:0] ext_pending_0to7;
    logic [7:0] ext_trig_type_0to7;
    logic [7:0] ext_sense_sel_0to7;
    logic [1:0] ext_gate_10_13;
    logic [1:0] ext_pending_10_13;
    logic [1:0] ext_trig_type_10_13;
    logic [1:0] ext_sense_sel_10_13;
    logic [3:0] evt_stat;
    logic [3:0] evt_mask;
    logic [9:0] line_prev;
    logic [3:0] in_svc;

    // ----------------------------------------
    // combinational nets
    // ----------------------------------------
    logic [9:0] line_in;
    logic [9:0] trig;
    logic [9:0] pol;
    logic [9:0] gate;
    logic [9:0] hit;
    logic global_en;
    logic [NUM_SRC-1:0] src_en;
    logic [NUM_SRC-1:0] pend;
    logic [NUM_SRC-1:0] req_vec;
    logic best_valid;
    irq_pkg::level_t best_lvl;
    irq_pkg::src_t best_num;
    irq_pkg::level_t top_lvl;
    logic next_req;
    logic wr_pend0;
    logic wr_pend1;
    logic take_ack;
    logic ack10;
    logic ack13;
    logic [3:0] next_stat;
    irq_pkg::level_t grp_lvl [0:`NUM_GROUPS-1];

    assign global_en = first_irq_enable[`BIT_GLOBAL_EN];
    assign wr_pend0 = REG_WR && (REG_ADDR == `OFS_PEND_0TO7);
    assign wr_pend1 = REG_WR && (REG_ADDR == `OFS_PEND_10_13);
    assign take_ack = ACK && IRQ_REQ;
    assign ack10 = take_ack && (IRQ_NUM == `SRC_EXT10);
    assign ack13 = take_ack && (IRQ_NUM == `SRC_EXT13);

    // ----------------------------------------
    // external line sensing
    // ----------------------------------------
    // line k of the low group is port 0 bit k; lines 8 and 9 are lines 10 and 13
    assign line_in = {EXT_13, EXT_10, EXT_P0};
    assign trig = {ext_trig_type_10_13, ext_trig_type_0to7};
    assign pol = {ext_sense_sel_10_13, ext_sense_sel_0to7};
    assign gate = {ext_gate_10_13, ext_gate_0to7};

    always_comb
    begin
        hit = ((trig & ~pol & ~line_prev & line_in)
              | (trig & pol & line_prev & ~line_in)
              | (~trig & (line_in ^ pol))) & gate;
    end

    always_ff @(posedge MCLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            line_prev <= 10'h000;
        else
            line_prev <= line_in;
    end

    // ----------------------------------------
    // pending flags
    // ----------------------------------------
    // a new trigger wins over a software clear in the same cycle
    always_ff @(posedge MCLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            ext_pending_0to7 <= `REG_RESET;
        else if (wr_pend0)
            ext_pending_0to7 <= (ext_pending_0to7 & REG_WDATA) | hit[7:0];
        else
            ext_pending_0to7 <= ext_pending_0to7 | hit[7:0];
    end

    always_ff @(posedge MCLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            ext_pending_10_13 <= 2'h0;
        else
        begin
            ext_pending_10_13[0] <= (ext_pending_10_13[0] & ~ack10
                                    & ~(wr_pend1 & ~REG_WDATA[0])) | hit[8];
            ext_pending_10_13[1] <= (ext_pending_10_13[1] & ~ack13
                                    & ~(wr_pend1 & ~REG_WDATA[1])) | hit[9];
        end
    end

    // ----------------------------------------
    // control registers
    // ----------------------------------------
    always_ff @(posedge MCLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            first_irq_enable <= `REG_RESET;
            timer_irq_enable <= `REG_RESET;
            misc_irq_enable <= `REG_RESET;
            prio_low_bits <= 6'h00;
            prio_high_bits <= 6'h00;
            ext_gate_0to7 <= `REG_RESET;
            ext_trig_type_0to7 <= `REG_RESET;
            ext_sense_sel_0to7 <= `REG_RESET;
            ext_gate_10_13 <= 2'h0;
            ext_trig_type_10_13 <= 2'h0;
            ext_sense_sel_10_13 <= 2'h0;
            evt_mask <= 4'h0;
        end
        else if (REG_WR)
        begin
            if (REG_ADDR == `OFS_FIRST_EN)
                first_irq_enable <= REG_WDATA & 8'hA6;
            else if (REG_ADDR == `OFS_TIMER_EN)
                timer_irq_enable <= REG_WDATA & 8'h1F;
            else if (REG_ADDR == `OFS_MISC_EN)
                misc_irq_enable <= REG_WDATA & 8'h1D;
            else if (REG_ADDR == `OFS_PRIO_LOW)
                prio_low_bits <= REG_WDATA[5:0];
            else if (REG_ADDR == `OFS_PRIO_HIGH)
                prio_high_bits <= REG_WDATA[5:0];
            else if (REG_ADDR == `OFS_GATE_0TO7)
                ext_gate_0to7 <= REG_WDATA;
            else if (REG_ADDR == `OFS_TRIG_0TO7)
                ext_trig_type_0to7 <= REG_WDATA;
            else if (REG_ADDR == `OFS_SENSE_0TO7)
                ext_sense_sel_0to7 <= REG_WDATA;
            else if (REG_ADDR == `OFS_GATE_10_13)
                ext_gate_10_13 <= REG_WDATA[1:0];
            else if (REG_ADDR == `OFS_TRIG_10_13)
                ext_trig_type_10_13 <= REG_WDATA[1:0];
            else if (REG_ADDR == `OFS_SENSE_10_13)
                ext_sense_sel_10_13 <= REG_WDATA[1:0];
            else if (REG_ADDR == `OFS_EVT_MASK)
                evt_mask <= REG_WDATA[3:0];
        end
    end

    // ----------------------------------------
    // source enables and requests
    // ----------------------------------------
    always_comb
    begin
        src_en = '0;
        src_en[`SRC_EXT10] = first_irq_enable[`BIT_EXT10_EN];
        src_en[`SRC_EXT13] = first_irq_enable[`BIT_EXT13_EN];
        src_en[`SRC_EXT_0TO7] = first_irq_enable[`BIT_EXT_0TO7_EN];
        src_en[`SRC_TIMER0_OVF +: 5] = timer_irq_enable[4:0];
        src_en[18] = misc_irq_enable[0];
        src_en[20] = misc_irq_enable[2];
        src_en[21] = misc_irq_enable[3];
        src_en[22] = misc_irq_enable[4];
    end

    always_comb
    begin
        pend = PERIPH_REQ;
        pend[`SRC_EXT10] = ext_pending_10_13[0];
        pend[`SRC_EXT13] = ext_pending_10_13[1];
        pend[`SRC_EXT_0TO7] = |(ext_pending_0to7 & ext_gate_0to7);
        req_vec = pend & src_en & {NUM_SRC{global_en}};
    end

    // ----------------------------------------
    // group levels and arbitration
    // ----------------------------------------
    // source n belongs to group n mod 6, so each group holds 4 sources
    always_comb
    begin
        for (int g = 0; g < `NUM_GROUPS; g++)
            grp_lvl[g] = {prio_high_bits[g], prio_low_bits[g]};
    end

    always_comb
    begin
        best_valid = 1'b0;
        best_lvl = 2'h0;
        best_num = 5'h00;
        // scanning downward with >= lets the lower number win ties
        for (int i = NUM_SRC - 1; i >= 0; i--)
        begin
            if (req_vec[i] && (!best_valid || grp_lvl[i % `NUM_GROUPS] >= best_lvl))
            begin
                best_valid = 1'b1;
                best_lvl = grp_lvl[i % `NUM_GROUPS];
                best_num = 5'(i);
            end
        end
    end

    always_comb
    begin
        top_lvl = 2'h0;
        for (int l = 0; l < 4; l++)
        begin
            if (in_svc[l])
                top_lvl = 2'(l);
        end
        next_req = best_valid && (in_svc == 4'h0 || best_lvl > top_lvl);
    end

    // ----------------------------------------
    // service tracking and core outputs
    // ----------------------------------------
    // one bit per level in service; nesting depth is bounded by the four levels
    always_ff @(posedge MCLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            in_svc <= 4'h0;
        else if (take_ack)
            in_svc <= in_svc | (4'h1 << IRQ_LEVEL);
        else if (SVC_DONE && in_svc != 4'h0)
            in_svc <= in_svc & ~(4'h1 << top_lvl);
    end

    always_ff @(posedge MCLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            IRQ_REQ <= 1'b0;
            IRQ_NUM <= 5'h00;
            IRQ_LEVEL <= 2'h0;
        end
        else
        begin
            IRQ_REQ <= next_req && !take_ack;
            IRQ_NUM <= best_num;
            IRQ_LEVEL <= best_lvl;
        end
    end

    // ----------------------------------------
    // event status and summary output
    // ----------------------------------------
    always_comb
    begin
        next_stat = evt_stat;
        if (REG_RD && REG_ADDR == `OFS_EVT_STAT)
            next_stat = 4'h0;
        next_stat = next_stat | {take_ack, hit[9], hit[8], |hit[7:0]};
    end

    always_ff @(posedge MCLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            evt_stat <= 4'h0;
            IRQ_OUT <= 1'b0;
        end
        else
        begin
            evt_stat <= next_stat;
            IRQ_OUT <= |(next_stat & evt_mask);
        end
    end

    // ----------------------------------------
    // register read
    // ----------------------------------------
    always_ff @(posedge MCLK or posedge SYS_RST)
    begin
        if (SYS_RST)
            REG_RDATA <= 8'h00;
        else if (!REG_RD)
            REG_RDATA <= 8'h00;
        else if (REG_ADDR == `OFS_FIRST_EN)
            REG_RDATA <= first_irq_enable;
        else if (REG_ADDR == `OFS_TIMER_EN)
            REG_RDATA <= timer_irq_enable;
        else if (REG_ADDR == `OFS_MISC_EN)
            REG_RDATA <= misc_irq_enable;
        else if (REG_ADDR == `OFS_PRIO_LOW)
            REG_RDATA <= {2'h0, prio_low_bits};
        else if (REG_ADDR == `OFS_PRIO_HIGH)
            REG_RDATA <= {2'h0, prio_high_bits};
        else if (REG_ADDR == `OFS_GATE_0TO7)
            REG_RDATA <= ext_gate_0to7;
        else if (REG_ADDR == `OFS_PEND_0TO7)
            REG_RDATA <= ext_pending_0to7;
        else if (REG_ADDR == `OFS_TRIG_0TO7)
            REG_RDATA <= ext_trig_type_0to7;
        else if (REG_ADDR == `OFS_SENSE_0TO7)
            REG_RDATA <= ext_sense_sel_0to7;
        else if (REG_ADDR == `OFS_GATE_10_13)
            REG_RDATA <= {6'h00, ext_gate_10_13};
        else if (REG_ADDR == `OFS_PEND_10_13)
            REG_RDATA <= {6'h00, ext_pending_10_13};
        else if (REG_ADDR == `OFS_TRIG_10_13)
            REG_RDATA <= {6'h00, ext_trig_type_10_13};
        else if (REG_ADDR == `OFS_SENSE_10_13)
            REG_RDATA <= {6'h00, ext_sense_sel_10_13};
        else if (REG_ADDR == `OFS_EVT_STAT)
            REG_RDATA <= {4'h0, evt_stat};
        else if (REG_ADDR == `OFS_EVT_MASK)
            REG_RDATA <= {4'h0, evt_mask};
        else
            REG_RDATA <= 8'h00;
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (SYS_RST);

    chk_master_gate: assert property (!global_en |=> !IRQ_REQ)
        else $error("request raised with master enable off");

    chk_flag_sticky: assert property (
        (|($past(ext_pending_0to7) & ~ext_pending_0to7)) |-> $past(wr_pend0))
        else $error("line 0-7 flag dropped without a write");

    chk_ack_clear: assert property (ack10 && !hit[8] |=> !ext_pending_10_13[0])
        else $error("line 10 flag kept after acknowledge");

    chk_rise_edge: assert property (
        trig[0] && !pol[0] && gate[0] && !line_prev[0] && line_in[0] |=> ext_pending_0to7[0])
        else $error("rising edge on line 0 not flagged");

    chk_low_level: assert property (
        !trig[8] && pol[8] && gate[8] && !EXT_10 |=> ext_pending_10_13[0])
        else $error("low level on line 10 not flagged");

    chk_line_gate: assert property (
        !gate[3] && !ext_pending_0to7[3] |=> !ext_pending_0to7[3])
        else $error("gated-off line 3 set its flag");

    chk_preempt_level: assert property (
        IRQ_REQ && $past(in_svc) != 4'h0 |-> IRQ_LEVEL > $past(top_lvl))
        else $error("request not above level in service");

    chk_grant_source: assert property (IRQ_REQ |-> $past(req_vec[best_num]))
        else $error("granted source was not requesting");

    chk_group_level: assert property (
        IRQ_REQ |-> IRQ_LEVEL == $past(grp_lvl[best_num % `NUM_GROUPS]))
        else $error("granted level differs from group level");

    chk_adc_enable: assert property (
        !misc_irq_enable[0] |=> !(IRQ_REQ && IRQ_NUM == `SRC_ADC))
        else $error("ADC request granted while disabled");

    chk_upper_zero: assert property (
        REG_RD && REG_ADDR == `OFS_PEND_10_13 |=> REG_RDATA[7:2] == 6'h00)
        else $error("upper bits of line 10/13 register not zero");

endmodule

/* irq_core_model.sv */
// core and peripheral request model at the far side of the interrupt block
`timescale 1ns/1ps

module irq_core_model (
    // clock and reset
    input wire logic MCLK,
    input wire logic SYS_RST,
    // offered request
    input wire logic IRQ_REQ,
    input wire logic [4:0] IRQ_NUM,
    // answers and on-chip requests
    output logic ACK,
    output logic SVC_DONE,
    output logic [23:0] PERIPH_REQ
);
    logic accept = 1'b0;
    logic [4:0] taken_num = 5'h00;
    int acks = 0;
    int ack_wait = 0;
    int seen = 0;

    initial
    begin
        ACK = 1'b0;
        SVC_DONE = 1'b0;
        PERIPH_REQ = 24'h000000;
    end

    // the core only takes an offer after it has stood for ack_wait cycles
    always @(posedge MCLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            ACK <= 1'b0;
            seen = 0;
        end
        else if (ACK)
        begin
            // a peripheral drops its request once its grant is taken
            ACK <= 1'b0;
            PERIPH_REQ[taken_num] <= 1'b0;
        end
        else if (accept && IRQ_REQ && seen >= ack_wait)
        begin
            ACK <= 1'b1;
            taken_num <= IRQ_NUM;
            acks++;
            seen = 0;
        end
        else
            seen = (accept && IRQ_REQ) ? seen + 1 : 0;
    end

    task automatic raise(input logic [23:0] m);
        @(posedge MCLK);
        PERIPH_REQ <= PERIPH_REQ | m;
    endtask

    task automatic lower(input logic [23:0] m);
        @(posedge MCLK);
        PERIPH_REQ <= PERIPH_REQ & ~m;
    endtask

    // return from service: one pulse ends the innermost service
    task automatic complete();
        @(posedge MCLK);
        SVC_DONE <= 1'b1;
        @(posedge MCLK);
        SVC_DONE <= 1'b0;
    endtask
endmodule

/* irq_ctrl_test.sv */
// self-checking bench of the interrupt enable, priority and external line block
`timescale 1ns/1ps
`include "irq_cfg.svh"

module irq_ctrl_test;
    logic MCLK;
    logic SYS_RST;
    logic [7:0] REG_ADDR;
    logic [7:0] REG_WDATA;
    logic REG_WR;
    logic REG_RD;
    logic [7:0] REG_RDATA;
    logic [7:0] EXT_P0;
    logic EXT_10;
    logic EXT_13;
    logic [23:0] PERIPH_REQ;
    logic ACK;
    logic SVC_DONE;
    logic IRQ_REQ;
    logic [4:0] IRQ_NUM;
    logic [1:0] IRQ_LEVEL;
    logic IRQ_OUT;
    int fail_count = 0;
    int num_checks = 0;
    // plain read-write registers and the bits that they keep
    logic [7:0] rw_ofs [12] = '{`OFS_GATE_10_13, `OFS_TRIG_10_13, `OFS_SENSE_10_13, `OFS_FIRST_EN,
        `OFS_TIMER_EN, `OFS_MISC_EN, `OFS_GATE_0TO7, `OFS_TRIG_0TO7, `OFS_SENSE_0TO7, `OFS_EVT_MASK,
        `OFS_PRIO_LOW, `OFS_PRIO_HIGH};
    logic [7:0] rw_keep [12] = '{8'h03, 8'h03, 8'h03, 8'hA6, 8'h1F, 8'h1D, 8'hFF, 8'hFF, 8'hFF, 8'h0F,
        8'h3F, 8'h3F};
    int src_num [9] = '{12, 13, 14, 15, 16, 18, 20, 21, 22};
    logic [7:0] src_bit [9] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h01, 8'h04, 8'h08, 8'h10};

    irq_ctrl #(.NUM_SRC(24)) u_irq_ctrl (.MCLK(MCLK), .SYS_RST(SYS_RST), .REG_ADDR(REG_ADDR),
        .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .EXT_P0(EXT_P0),
        .EXT_10(EXT_10), .EXT_13(EXT_13), .PERIPH_REQ(PERIPH_REQ), .ACK(ACK), .SVC_DONE(SVC_DONE),
        .IRQ_REQ(IRQ_REQ), .IRQ_NUM(IRQ_NUM), .IRQ_LEVEL(IRQ_LEVEL), .IRQ_OUT(IRQ_OUT));

    irq_core_model u_irq_core_model (.MCLK(MCLK), .SYS_RST(SYS_RST), .IRQ_REQ(IRQ_REQ),
        .IRQ_NUM(IRQ_NUM), .ACK(ACK), .SVC_DONE(SVC_DONE), .PERIPH_REQ(PERIPH_REQ));

    initial
    begin
        MCLK = 1'b0;
        forever #12.5 MCLK = ~MCLK;
    end

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge MCLK);
        REG_ADDR <= a;
        REG_WDATA <= d;
        REG_WR <= 1'b1;
        @(posedge MCLK);
        REG_WR <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge MCLK);
        REG_ADDR <= a;
        REG_RD <= 1'b1;
        @(posedge MCLK);
        REG_RD <= 1'b0;
        #1;
        check($sformatf("register %h", a), exp, REG_RDATA);
    endtask

    // grant is {request, level, number}; with no request only the flag counts
    task automatic core(input logic [7:0] exp);
        repeat (3) @(posedge MCLK);
        #1;
        if (exp[7])
            check("grant", exp, {IRQ_REQ, IRQ_LEVEL, IRQ_NUM});
        else
            check("grant", 8'h00, {7'h00, IRQ_REQ});
    endtask

    task automatic out(input logic exp);
        repeat (2) @(posedge MCLK);
        #1;
        check("event output", {7'h00, exp}, {7'h00, IRQ_OUT});
    endtask

    task automatic take(input int w);
        int n;
        n = u_irq_core_model.acks;
        u_irq_core_model.ack_wait = w;
        u_irq_core_model.accept = 1'b1;
        repeat (20)
            if (u_irq_core_model.acks == n)
                @(posedge MCLK);
        u_irq_core_model.accept = 1'b0;
        // let the model drop the granted request before the next stimulus
        @(posedge MCLK);
        check("ack count", 8'h01, 8'(u_irq_core_model.acks - n));
    endtask

    task automatic port0(input logic [7:0] v);
        @(posedge MCLK);
        EXT_P0 <= v;
        repeat (2) @(posedge MCLK);
    endtask

    task automatic pins(input logic v10, input logic v13);
        @(posedge MCLK);
        EXT_10 <= v10;
        EXT_13 <= v13;
        repeat (2) @(posedge MCLK);
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        SYS_RST = 1'b1;
        REG_ADDR = 8'h00;
        REG_WDATA = 8'h00;
        REG_WR = 1'b0;
        REG_RD = 1'b0;
        EXT_P0 = 8'h00;
        EXT_10 = 1'b0;
        EXT_13 = 1'b0;
        repeat (6) @(posedge MCLK);
        SYS_RST <= 1'b0;
        foreach (rw_ofs[i])
            rd(rw_ofs[i], 8'h00);
        rd(`OFS_PEND_10_13, 8'h00);
        rd(`OFS_PEND_0TO7, 8'h00);
        foreach (rw_ofs[i])
            wr(rw_ofs[i], 8'hFF);
        foreach (rw_ofs[i])
            rd(rw_ofs[i], rw_keep[i]);
        foreach (rw_ofs[i])
            wr(rw_ofs[i], 8'h00);
        wr(8'hA0, 8'hFF);
        rd(8'hA0, 8'h00);
        $display("test registers done");
        // each sense mode on its own port bit
        for (int k = 0; k < 4; k++)
        begin
            logic [7:0] b;
            logic t;
            logic p;
            b = 8'h02 << (2 * k);
            t = k[1];
            p = k[0];
            port0(p ? b : 8'h00);
            wr(`OFS_TRIG_0TO7, t ? b : 8'h00);
            wr(`OFS_SENSE_0TO7, p ? b : 8'h00);
            wr(`OFS_GATE_0TO7, b);
            wr(`OFS_PEND_0TO7, 8'h00);
            rd(`OFS_PEND_0TO7, 8'h00);
            port0(p ? 8'h00 : b);
            rd(`OFS_PEND_0TO7, b);
            wr(`OFS_PEND_0TO7, 8'h00);
            rd(`OFS_PEND_0TO7, t ? 8'h00 : b);
            port0(p ? b : 8'h00);
            rd(`OFS_PEND_0TO7, t ? 8'h00 : b);
            wr(`OFS_GATE_0TO7, 8'h00);
            wr(`OFS_PEND_0TO7, 8'h00);
            port0(p ? 8'h00 : b);
            rd(`OFS_PEND_0TO7, 8'h00);
            port0(p ? b : 8'h00);
        end
        wr(`OFS_GATE_0TO7, 8'h80);
        port0(8'h00);
        wr(`OFS_FIRST_EN, 8'hA0);
        core(8'h85);
        wr(`OFS_FIRST_EN, 8'h00);
        out(1'b0);
        wr(`OFS_EVT_MASK, 8'h01);
        out(1'b1);
        rd(`OFS_EVT_STAT, 8'h01);
        out(1'b0);
        wr(`OFS_EVT_MASK, 8'h00);
        $display("test port lines done");
        wr(`OFS_TRIG_10_13, 8'h03);
        wr(`OFS_GATE_10_13, 8'h02);
        pins(1'b1, 1'b1);
        wr(`OFS_PEND_10_13, 8'h01);
        rd(`OFS_PEND_10_13, 8'h00);
        pins(1'b0, 1'b0);
        pins(1'b1, 1'b1);
        rd(`OFS_PEND_10_13, 8'h02);
        wr(`OFS_FIRST_EN, 8'h04);
        core(8'h00);
        wr(`OFS_FIRST_EN, 8'h84);
        core(8'h82);
        take(3);
        rd(`OFS_PEND_10_13, 8'h00);
        u_irq_core_model.complete();
        wr(`OFS_GATE_10_13, 8'h01);
        pins(1'b0, 1'b0);
        pins(1'b1, 1'b1);
        rd(`OFS_PEND_10_13, 8'h01);
        wr(`OFS_FIRST_EN, 8'h82);
        core(8'h81);
        take(0);
        rd(`OFS_PEND_10_13, 8'h00);
        u_irq_core_model.complete();
        wr(`OFS_GATE_10_13, 8'h00);
        rd(`OFS_EVT_STAT, 8'h0E);
        $display("test lines 10 and 13 done");
        wr(`OFS_FIRST_EN, 8'h80);
        for (int i = 0; i < 9; i++)
        begin
            u_irq_core_model.raise(24'h000001 << src_num[i]);
            wr(i < 5 ? `OFS_TIMER_EN : `OFS_MISC_EN, src_bit[i]);
            core({3'b100, 5'(src_num[i])});
            wr(i < 5 ? `OFS_TIMER_EN : `OFS_MISC_EN, 8'h00);
            core(8'h00);
            u_irq_core_model.lower(24'h000001 << src_num[i]);
        end
        $display("test source enables done");
        wr(`OFS_TIMER_EN, 8'h1F);
        u_irq_core_model.raise(24'h007000);
        core(8'h8C);
        wr(`OFS_PRIO_LOW, 8'h04);
        core(8'hAE);
        wr(`OFS_PRIO_HIGH, 8'h02);
        core(8'hCD);
        wr(`OFS_PRIO_LOW, 8'h0E);
        wr(`OFS_PRIO_HIGH, 8'h0A);
        core(8'hED);
        take(0);
        u_irq_core_model.raise(24'h008000);
        core(8'h00);
        u_irq_core_model.complete();
        core(8'hEF);
        wr(`OFS_PRIO_LOW, 8'h06);
        wr(`OFS_PRIO_HIGH, 8'h02);
        core(8'hAE);
        take(0);
        core(8'h00);
        wr(`OFS_PRIO_HIGH, 8'h03);
        core(8'hCC);
        take(0);
        u_irq_core_model.complete();
        core(8'h00);
        u_irq_core_model.complete();
        core(8'h8F);
        wr(`OFS_FIRST_EN, 8'h00);
        core(8'h00);
        $display("test priority done");
        conclude();
    end

    // the whole sequence needs some 530 cycles
    initial
    begin
        repeat (20000) @(posedge MCLK);
        fail_count++;
        $display("Error watchdog expected finish seen timeout");
        conclude();
    end
endmodule
